/* File: hdl/fan_pwm_floor_and_ramp.sv */
// register file, floor duty and slew limiter of the fan drive
`timescale 1ns/1ps
// What this block does
// - duty changes from the remote 2 loop reach the drive output gradually at a limited rate.
// - table 0 steps 1,2,3,4,8,12,24,48 per slot, full ramp 37.5 s down to 0.8 s.
// - table 1 uses a slower slot, full ramp 52.2 s at code 000 and shorter above.
// - once the lock bit is set writes to the ramp-rate register are ignored.
// - three 8-bit floor duty registers reset to 0x80.
// - floor duty is linear, 0x00 off through 0xFF full speed.
// - in auto mode the floor duty is the least duty applied to each output.
// - in auto mode the floor duty registers are read only.
// ==========================================================================
// how the pieces fit together
// the host writes the wanted duty of the remote 2 loop into the target
// register; the slew limiter walks the ramped duty toward it one step per
// slot, so a sudden change of demand never reaches the fan as a jump
// the slot length is the only thing the table select bit changes, which
// keeps one step table for both tables at the cost of a single ratio
// between them; a user who needs per-code timing must widen this later
// the floor duty acts only while the automatic loop owns the outputs; in
// manual mode every output simply follows the ramped duty
// the lock bit freezes the ramp code and the table select, and nothing but
// a reset clears it, so a runaway host cannot unlock the ramp settings
// read data stand for exactly one cycle after the read strobe and are zero
// otherwise, which lets the host ignore the read data bus between reads
// all three outputs are registered, so each one lags the ramped duty by
// one clock; that lag is far below any slot length that makes sense
module fan_pwm_floor_and_ramp #(
  parameter longint FAST_SLOT_CYC = fan_ramp_pkg::FAST_SLOT,
  parameter longint SLOW_SLOT_CYC = fan_ramp_pkg::SLOW_SLOT
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  RSTN,
  input  wire fan_ramp_pkg::bus_req_s BUS,
  output logic [7:0]                 RDATA,
  output logic [7:0]                 DUTY1,
  output logic [7:0]                 DUTY2,
  output logic [7:0]                 DUTY3,
  output logic                       LOCKED
);
  // ==========================================================================
  // address decode
  wire w_floor1 = BUS.wr && BUS.addr == fan_ramp_pkg::FLOOR1_ADDR;
  wire w_floor2 = BUS.wr && BUS.addr == fan_ramp_pkg::FLOOR2_ADDR;
  wire w_floor3 = BUS.wr && BUS.addr == fan_ramp_pkg::FLOOR3_ADDR;
  wire w_ramp   = BUS.wr && BUS.addr == fan_ramp_pkg::RAMP_ADDR;
  wire w_cfg1   = BUS.wr && BUS.addr == fan_ramp_pkg::CFG1_ADDR;
  wire w_cfg6   = BUS.wr && BUS.addr == fan_ramp_pkg::CFG6_ADDR;
  wire w_target = BUS.wr && BUS.addr == fan_ramp_pkg::TARGET_ADDR;

  logic [7:0] floor1_q, floor2_q, floor3_q;
  logic [2:0] code_q;
  logic       lock_q, auto_q, tsel_q;
  logic [7:0] target_q, duty_q;
  logic [39:0] slot_q;

  // floor writes are refused in auto mode, ramp writes once locked
  wire floor_ok = !auto_q;
  wire ramp_ok  = !lock_q;

  // ==========================================================================
  // registers
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      floor1_q <= fan_ramp_pkg::FLOOR_RST;
      floor2_q <= fan_ramp_pkg::FLOOR_RST;
      floor3_q <= fan_ramp_pkg::FLOOR_RST;
      code_q   <= 3'h0;
      lock_q   <= 1'b0;
      auto_q   <= 1'b0;
      tsel_q   <= 1'b0;
      target_q <= fan_ramp_pkg::ZERO8;
    end else begin
      if (w_floor1 && floor_ok) floor1_q <= BUS.wdata;
      if (w_floor2 && floor_ok) floor2_q <= BUS.wdata;
      if (w_floor3 && floor_ok) floor3_q <= BUS.wdata;
      if (w_ramp && ramp_ok) code_q <= BUS.wdata[fan_ramp_pkg::CODE_LSB +: 3];
      if (w_cfg1) begin
        // lock only sets; a clear needs reset
        lock_q <= lock_q | BUS.wdata[fan_ramp_pkg::LOCK_BIT];
        auto_q <= BUS.wdata[fan_ramp_pkg::AUTO_BIT];
      end
      if (w_cfg6 && ramp_ok) tsel_q <= BUS.wdata[fan_ramp_pkg::TSEL_BIT];
      if (w_target) target_q <= BUS.wdata;
    end
  end

  // ==========================================================================
  // slew limiter: one step per slot, never past the target
  logic [5:0] step;
  always_comb begin
    unique case (code_q)
      3'h0: step = 6'h01;
      3'h1: step = 6'h02;
      3'h2: step = 6'h03;
      3'h3: step = 6'h04;
      3'h4: step = 6'h08;
      3'h5: step = 6'h0C;
      3'h6: step = 6'h18;
      3'h7: step = 6'h30;
    endcase
  end
  // table 1 stretches the slot, so every code slows by the same ratio
  wire [39:0] slot_len = tsel_q ? 40'(SLOW_SLOT_CYC) : 40'(FAST_SLOT_CYC);
  wire        slot_end = slot_q >= slot_len - 40'h1;
  wire [8:0]  up_sum   = {1'b0, duty_q} + {3'h0, step};
  wire [8:0]  dn_dif   = {1'b0, duty_q} - {3'h0, step};
  logic [7:0] duty_d;
  always_comb begin
    duty_d = duty_q;
    if (slot_end && target_q > duty_q)
      duty_d = (up_sum[8] || up_sum[7:0] > target_q) ? target_q : up_sum[7:0];
    else if (slot_end && target_q < duty_q)
      duty_d = (dn_dif[8] || dn_dif[7:0] < target_q) ? target_q : dn_dif[7:0];
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      slot_q <= 40'h0;
      duty_q <= fan_ramp_pkg::ZERO8;
    end else begin
      slot_q <= slot_end ? 40'h0 : slot_q + 40'h1;
      duty_q <= duty_d;
    end
  end

  // ==========================================================================
  // outputs: floor applies only under the automatic loop
  wire [7:0] o1_d = (auto_q && duty_q < floor1_q) ? floor1_q : duty_q;
  wire [7:0] o2_d = (auto_q && duty_q < floor2_q) ? floor2_q : duty_q;
  wire [7:0] o3_d = (auto_q && duty_q < floor3_q) ? floor3_q : duty_q;
  logic [7:0] rd_d;
  always_comb begin
    rd_d = fan_ramp_pkg::ZERO8;
    if (BUS.rd) begin
      unique case (BUS.addr)
        fan_ramp_pkg::FLOOR1_ADDR: rd_d = floor1_q;
        fan_ramp_pkg::FLOOR2_ADDR: rd_d = floor2_q;
        fan_ramp_pkg::FLOOR3_ADDR: rd_d = floor3_q;
        fan_ramp_pkg::RAMP_ADDR:   rd_d = {1'b0, code_q, 4'h0};
        fan_ramp_pkg::CFG1_ADDR:   rd_d = {6'h00, lock_q, auto_q};
        fan_ramp_pkg::CFG6_ADDR:   rd_d = {tsel_q, 7'h00};
        fan_ramp_pkg::TARGET_ADDR: rd_d = target_q;
        fan_ramp_pkg::DUTY_ADDR:   rd_d = duty_q;
        default:                   rd_d = fan_ramp_pkg::ZERO8;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA  <= fan_ramp_pkg::ZERO8;
      DUTY1  <= fan_ramp_pkg::ZERO8;
      DUTY2  <= fan_ramp_pkg::ZERO8;
      DUTY3  <= fan_ramp_pkg::ZERO8;
      LOCKED <= 1'b0;
    end else begin
      RDATA  <= rd_d;
      DUTY1  <= o1_d;
      DUTY2  <= o2_d;
      DUTY3  <= o3_d;
      LOCKED <= lock_q;
    end
  end

  // ==========================================================================
  // checks
  lock_sticky_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    lock_q |=> lock_q) else $error("lock bit cleared");
  ramp_locked_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (lock_q && w_ramp) |=> $stable(code_q)) else $error("ramp code written while locked");
  floor_auto_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (auto_q && w_floor1) |=> floor1_q == $past(floor1_q)) else $error("floor written in auto");
  slew_step_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !slot_end |=> $stable(duty_q)) else $error("duty moved between slots");
  step_size_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (slot_end && code_q == 3'h7 && target_q > 8'h60 && duty_q < 8'h20)
      |=> duty_q == $past(duty_q) + 8'h30) else $error("wrong step for code 7");
  floor_out_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    auto_q |=> DUTY1 >= $past(floor1_q)) else $error("output below floor");

  // ==========================================================================
  // floor register checks: writes land in manual mode, bounce in auto mode
  floor2_auto_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (auto_q && w_floor2) |=> floor2_q == $past(floor2_q))
    else $error("floor 2 written in auto");

  floor3_auto_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (auto_q && w_floor3) |=> floor3_q == $past(floor3_q))
    else $error("floor 3 written in auto");

  floor1_write_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (!auto_q && w_floor1) |=> floor1_q == $past(BUS.wdata))
    else $error("floor 1 write lost");

  floor2_write_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (!auto_q && w_floor2) |=> floor2_q == $past(BUS.wdata))
    else $error("floor 2 write lost");

  floor3_write_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (!auto_q && w_floor3) |=> floor3_q == $past(BUS.wdata))
    else $error("floor 3 write lost");

  // ==========================================================================
  // output checks: floor in auto mode, plain ramped duty otherwise
  floor2_out_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    auto_q |=> DUTY2 >= $past(floor2_q))
    else $error("output 2 below floor");

  floor3_out_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    auto_q |=> DUTY3 >= $past(floor3_q))
    else $error("output 3 below floor");

  manual_out_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !auto_q |=> DUTY1 == $past(duty_q))
    else $error("manual output not the ramped duty");

  above_floor_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (auto_q && duty_q >= floor1_q) |=> DUTY1 == $past(duty_q))
    else $error("output lifted above the ramped duty");

  // ==========================================================================
  // lock checks: code writes land while unlocked, table select frozen, lock sets and reaches LOCKED
  ramp_write_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (!lock_q && w_ramp) |=> code_q == $past(BUS.wdata[fan_ramp_pkg::CODE_LSB +: 3]))
    else $error("ramp code write lost");

  tsel_locked_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (lock_q && w_cfg6) |=> $stable(tsel_q))
    else $error("table select written while locked");

  lock_set_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (w_cfg1 && BUS.wdata[fan_ramp_pkg::LOCK_BIT]) |=> lock_q)
    else $error("lock bit did not set");

  lock_pin_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    lock_q |=> LOCKED)
    else $error("lock output lags the lock bit");

  // ==========================================================================
  // slew checks: every slot end moves toward an unreached target and never past it, a reached target holds
  slew_up_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (slot_end && target_q > duty_q) |=> duty_q > $past(duty_q) && duty_q <= $past(target_q))
    else $error("upward step overshoots");

  slew_down_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (slot_end && target_q < duty_q) |=> duty_q < $past(duty_q) && duty_q >= $past(target_q))
    else $error("downward step overshoots");

  slew_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (target_q == duty_q) |=> $stable(duty_q))
    else $error("duty left a reached target");

  step_max_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (slot_end && target_q > duty_q) |=> (duty_q - $past(duty_q)) <= 8'h30)
    else $error("step larger than the largest code");

  step_one_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (slot_end && code_q == 3'h0 && target_q > duty_q) |=> duty_q == $past(duty_q) + 8'h01)
    else $error("wrong step for code 0");

  step_eight_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (slot_end && code_q == 3'h4 && target_q > 8'hF0 && duty_q < 8'h80)
      |=> duty_q == $past(duty_q) + 8'h08)
    else $error("wrong step for code 4");

  // ==========================================================================
  // slot counter checks: it wraps at the slot end and counts up otherwise
  slot_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    slot_end |=> slot_q == 40'h0)
    else $error("slot counter did not wrap");

  slot_count_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !slot_end |=> slot_q == $past(slot_q) + 40'h1)
    else $error("slot counter skipped");

  // ==========================================================================
  // read path checks: data stand in the cycle after the strobe
  rd_floor_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (BUS.rd && BUS.addr == fan_ramp_pkg::FLOOR1_ADDR) |=> RDATA == $past(floor1_q))
    else $error("floor 1 read wrong");

  rd_duty_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (BUS.rd && BUS.addr == fan_ramp_pkg::DUTY_ADDR) |=> RDATA == $past(duty_q))
    else $error("duty read wrong");

  rd_code_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (BUS.rd && BUS.addr == fan_ramp_pkg::RAMP_ADDR) |=> RDATA[6:4] == $past(code_q))
    else $error("ramp code read wrong");
endmodule : fan_pwm_floor_and_ramp

/* File: pkg/fan_ramp_pkg.sv */
// constants and carrier types for the fan floor-duty and ramp block
package fan_ramp_pkg;
  // ==========================================================================
  // register map (printed offsets, kept as indices; byte address is not used)
  localparam logic [7:0] FLOOR1_ADDR  = 8'h64;
  localparam logic [7:0] FLOOR2_ADDR  = 8'h65;
  localparam logic [7:0] FLOOR3_ADDR  = 8'h66;
  localparam logic [7:0] RAMP_ADDR    = 8'h62;  // ramp code [6:4]
  localparam logic [7:0] CFG1_ADDR    = 8'h40;  // lock [1], auto mode [0]
  localparam logic [7:0] CFG6_ADDR    = 8'h10;  // table select [7]
  localparam logic [7:0] TARGET_ADDR  = 8'h90;  // wanted duty from remote 2 loop
  localparam logic [7:0] DUTY_ADDR    = 8'h91;  // ramped duty, read only
  // ==========================================================================
  // field positions and reset values
  localparam int         LOCK_BIT     = 1;
  localparam int         AUTO_BIT     = 0;
  localparam int         TSEL_BIT     = 7;
  localparam int         CODE_LSB     = 4;
  localparam logic [7:0] FLOOR_RST    = 8'h80;
  localparam logic [7:0] DUTY_FULL    = 8'hFF;
  localparam logic [7:0] ZERO8        = 8'h00;
  // ==========================================================================
  // ramp timing: full scale (255 counts) over the code 000 time
  localparam int         CLK_HZ       = 125_000_000;
  localparam int         FAST_MS      = 37500;   // 37.5 s at code 000, table 0
  localparam int         SLOW_MS      = 52200;   // 52.2 s at code 000, table 1
  localparam longint     FAST_SLOT    = (longint'(FAST_MS) * 125_000) / 255;
  localparam longint     SLOW_SLOT    = (longint'(SLOW_MS) * 125_000) / 255;
  // ==========================================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;
endpackage : fan_ramp_pkg

/* File: tb/fan_model.sv */
// fan load model: rotor speed trails the applied drive duty
`timescale 1ns/1ps
module fan_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] duty,
  output logic [7:0]      speed
);
  // rotor inertia: one count per clock toward the drive, never a jump
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) speed <= 8'h00;
    else if (speed < duty) speed <= speed + 8'h01;
    else if (speed > duty) speed <= speed - 8'h01;
  end
endmodule : fan_model

/* File: tb/tb.sv */
// self-checking bench for the fan floor-duty and ramp block
`timescale 1ns/1ps
module tb;
  logic                   ref_clk = 1'b0;
  logic                   rstn    = 1'b0;
  fan_ramp_pkg::bus_req_s bus     = '0;
  logic [7:0]             rdata, duty1, duty2, duty3, rd_v;
  logic                   locked;
  logic [7:0]             speed1;
  int                     mismatches = 0, samples_checked = 0, cycles = 0;
  int                     steps[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  // ==========================================================================
  // short slots (4 and 6 cycles) keep the full-scale ramps brief
  fan_pwm_floor_and_ramp #(.FAST_SLOT_CYC(4), .SLOW_SLOT_CYC(6)) dut_u (.REF_CLK(ref_clk),
    .RSTN(rstn), .BUS(bus), .RDATA(rdata), .DUTY1(duty1), .DUTY2(duty2), .DUTY3(duty3),
    .LOCKED(locked));
  fan_model fan_u (.clk(ref_clk), .rstn(rstn), .duty(duty1), .speed(speed1));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // hang guard, well above the longest ramp sequence
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ==========================================================================
  // bus cycles: one-cycle strobes with an idle cycle after each
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
    @(posedge ref_clk) bus.wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    bus.addr <= a; bus.rd <= 1'b1;
    @(posedge ref_clk) bus.rd <= 1'b0;
    #1 rd_v = rdata;
    @(posedge ref_clk);
  endtask : rd_reg
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // every change of the drive is one step, or the rest to the target, one slot after the last
  task automatic ramp(input logic tsel, input logic [2:0] code, input logic [7:0] tgt);
    int step, gap, n;
    logic [7:0] prev;
    step = steps[code];
    wr_reg(fan_ramp_pkg::CFG6_ADDR, {tsel, 7'h00});
    wr_reg(fan_ramp_pkg::RAMP_ADDR, {1'b0, code, 4'h0});
    wr_reg(fan_ramp_pkg::TARGET_ADDR, tgt);
    #1 prev = duty1;
    gap = -1; n = 0;
    while (duty1 !== tgt && n < 2000) begin
      @(posedge ref_clk) #1 n++;
      if (gap >= 0) gap++;
      if (duty1 !== prev) begin
        chk("step", (tgt > prev) ? ((tgt - prev > step) ? prev + step[7:0] : tgt)
            : ((prev - tgt > step) ? prev - step[7:0] : tgt), duty1);
        if (gap >= 0) chk("slot", tsel ? 8'h06 : 8'h04, gap[7:0]);
        gap = 0; prev = duty1;
      end
    end
    chk("ramp end", tgt, duty1);
    rd_reg(fan_ramp_pkg::DUTY_ADDR);
    chk("duty readback", tgt, rd_v);
    rd_reg(fan_ramp_pkg::TARGET_ADDR);
    chk("target readback", tgt, rd_v);
    @(posedge ref_clk);
  endtask : ramp
  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      rd_reg(fan_ramp_pkg::FLOOR1_ADDR + 8'(i));
      chk("floor reset", fan_ramp_pkg::FLOOR_RST, rd_v);
    end
    rd_reg(8'h01);
    chk("unmapped", 8'h00, rd_v);
    for (int i = 0; i < 12; i++) ramp(i >= 8, 3'(i), i[0] ? 8'h00 : 8'hFF);
    // floor in automatic mode, then protection against writes
    wr_reg(fan_ramp_pkg::FLOOR1_ADDR, 8'h40);
    rd_reg(fan_ramp_pkg::FLOOR1_ADDR);
    chk("floor write", 8'h40, rd_v);
    wr_reg(fan_ramp_pkg::CFG1_ADDR, 8'h01);
    repeat (3) @(posedge ref_clk);
    #1 chk("duty1 floor", 8'h40, duty1);
    chk("duty3 floor", 8'h80, duty3);
    chk("duty2 floor", 8'h80, duty2);
    repeat (70) @(posedge ref_clk);
    #1 chk("fan speed", 8'h40, speed1);
    wr_reg(fan_ramp_pkg::FLOOR1_ADDR, 8'hFF);
    rd_reg(fan_ramp_pkg::FLOOR1_ADDR);
    chk("floor in auto", 8'h40, rd_v);
    // lock: ramp code frozen, lock cannot be cleared
    wr_reg(fan_ramp_pkg::CFG1_ADDR, 8'h02);
    wr_reg(fan_ramp_pkg::RAMP_ADDR, 8'h70);
    rd_reg(fan_ramp_pkg::RAMP_ADDR);
    chk("ramp locked", 8'h30, rd_v);
    wr_reg(fan_ramp_pkg::CFG1_ADDR, 8'h00);
    #1 chk("lock held", 8'h01, {7'h00, locked});
    finish_test();
  end
endmodule : tb
